// ### design/hrp_pkg.sv
package hrp_pkg;

   // ==========================================================
   // Register map, byte addresses as seen on the parallel bus
   // ==========================================================
   localparam logic [13:0] OFF_INT_ENABLE   = 14'h2584;
   localparam logic [13:0] OFF_INT_CAUSE    = 14'h2586;
   localparam logic [13:0] OFF_PEND_CH_SEL  = 14'h2588;
   localparam logic [13:0] OFF_ACT_CH_SEL   = 14'h258A;
   localparam logic [13:0] OFF_PEND_CH_FILT = 14'h258C;
   localparam logic [13:0] OFF_ACT_FILT_A   = 14'h258E;
   localparam logic [13:0] OFF_ACT_FILT_B   = 14'h2590;
   localparam logic [13:0] OFF_TRACK_SEL    = 14'h2592;
   localparam logic [13:0] OFF_BUF_HANDLING = 14'h2594;
   localparam logic [13:0] OFF_CHIP_CTL     = 14'h2596;
   localparam logic [13:0] OFF_ADPCM_MIRROR = 14'h259A;
   localparam logic [13:0] OFF_AUDIO_LEFT   = 14'h25A0;
   localparam logic [13:0] OFF_AUDIO_RIGHT  = 14'h25A2;
   localparam logic [13:0] OFF_AUDIO_LOUD   = 14'h25A4;
   localparam logic [13:0] OFF_AUDIO_CTL    = 14'h25A6;
   localparam logic [13:0] OFF_AUDIO_SETUP  = 14'h25A8;
   localparam logic [13:0] OFF_AUDIO_STATE  = 14'h25AA;
   localparam logic [13:0] OFF_INT_STEER    = 14'h25C0;
   localparam logic [13:0] OFF_XFER_CTL     = 14'h25C2;
   localparam logic [13:0] OFF_MICROCODE    = 14'h25FE;

   // ==========================================================
   // Storage and field layout
   // ==========================================================
   localparam int          IDX_W         = 6;
   localparam int          MEM_DEPTH     = 64;
   localparam logic [15:0] REG_RESET     = 16'h0000;
   localparam int          CAUSE_W       = 2;
   localparam int          CAUSE_DMA_END = 0;
   localparam int          CAUSE_DMA_WORD = 1;
   localparam int          CTL_TEST_BIT  = 0;
   localparam int          XFER_START_BIT = 0;

   // ==========================================================
   // Serial link
   // ==========================================================
   localparam logic [1:0]  OP_WRITE     = 2'h0;
   localparam logic [1:0]  OP_READ      = 2'h1;
   localparam logic [1:0]  OP_ADDR      = 2'h2;
   localparam logic [1:0]  OP_NONE      = 2'h3;
   localparam logic [3:0]  SER_LAST_BIT = 4'hF;

   // ==========================================================
   // Clocking
   // ==========================================================
   localparam int unsigned OSC_HZ     = 32'h0204_CC00;
   localparam int unsigned SYS_OUT_HZ = 32'h0102_6600;
   localparam int unsigned OSC_DIVIDE = OSC_HZ / SYS_OUT_HZ;

   // ==========================================================
   // State machines
   // ==========================================================
   typedef enum logic [1:0] {P_IDLE, P_RD, P_ACK, P_PULL} hrp_pstate_t;
   typedef enum logic [2:0] {D_IDLE, D_REQ, D_XFER, D_RDY, D_REL} hrp_dstate_t;

endpackage

// ### design/hrp_mem_if.sv
`timescale 1ns/10ps
interface hrp_mem_if;
   logic        we;
   logic [5:0]  waddr;
   logic [15:0] wdata;
   logic [5:0]  raddr;
   logic [15:0] rdata;
   modport ctrl (output we, waddr, wdata, raddr, input rdata);
   modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

// ### design/hrp_regmem.sv
`timescale 1ns/10ps
module hrp_regmem (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Access port
   hrp_mem_if.mem   port
);

   logic [15:0] word_reg [hrp_pkg::MEM_DEPTH];
   logic [15:0] rdata_reg;

   // ==========================================================
   // One word per register slot, all cleared by reset
   // ==========================================================
   genvar i;
   generate
      for (i = 0; i < hrp_pkg::MEM_DEPTH; i++) begin : g_word
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               word_reg[i] <= hrp_pkg::REG_RESET;
            end else if (port.we && port.waddr == 6'(i)) begin
               word_reg[i] <= port.wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_reg <= hrp_pkg::REG_RESET;
      end else begin
         rdata_reg <= word_reg[port.raddr];
      end
   end

   assign port.rdata = rdata_reg;

endmodule

// ### design/hrp_host_port.sv
`timescale 1ns/10ps
// What this block does
// - Device select low qualifies every access; otherwise the parallel bus is ignored.
// - Direction low means write into the device, high means read.
// - Device drives acknowledge low when data is ready, then drives it high.
// - During DMA the acknowledge pin is an input: memory data is on the bus.
// - Write data valid while selected; read data presented in the same cycle acknowledge falls.
// - Interrupt output is low while enabled causes pend; cause read releases it.
// - Device requests DMA; far side grants before any transfer starts.
// - DMA ready goes low per transfer, is driven high, then floats.
// - Done low on a transfer makes it the last of the burst.
// - Serial ops: 00 write, 01 read, 10 load address, 11 nothing.
// - Strap 0 enables only serial, strap 1 only parallel.
// - Double-rate oscillator input is halved onto the system clock output.
// - Active-low reset clears the whole port and all registers.
// - Test indicator is 0 in normal operation, 1 in test mode.
// - Pending channel select at 2588, active channel select at 258A.
// - Audio left, right and loudness at 25A0, 25A2, 25A4.
module hrp_host_port (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        global_reset_n,
   // Clock pins
   input  wire logic        oscillator_double_in,
   output logic             divided_clock_output,
   // Strap and test
   input  wire logic        host_port_select,
   output logic             test_indicator,
   // Parallel bus
   input  wire logic [13:1] word_addr,
   input  wire logic        dev_select_n,
   input  wire logic        read_not_write,
   input  wire logic [15:0] data_in,
   output logic      [15:0] data_out,
   output logic             data_oe,
   input  wire logic        transfer_acknowledge_n_in,
   output logic             transfer_acknowledge_n_out,
   output logic             transfer_acknowledge_n_oe,
   // Interrupt
   output logic             alert_n,
   input  wire logic        alert_acknowledge_n,
   // DMA handshake
   output logic             dma_request_n,
   input  wire logic        dma_grant_n,
   output logic             dma_ready_n_out,
   output logic             dma_ready_n_oe,
   input  wire logic        dma_done_n,
   // Serial link
   input  wire logic        serial_clock,
   input  wire logic        serial_data_in,
   output logic             serial_data_out,
   input  wire logic [1:0]  serial_op
);

   logic                         rst;
   logic                         osc_q_reg;
   logic                         div_reg;
   hrp_pkg::hrp_pstate_t         pstate_reg;
   hrp_pkg::hrp_dstate_t         dstate_reg;
   logic [15:0]                  data_out_reg;
   logic                         data_oe_reg;
   logic                         last_reg;
   logic [hrp_pkg::CAUSE_W-1:0]  cause_reg;
   logic [hrp_pkg::CAUSE_W-1:0]  cause_next;
   logic [hrp_pkg::CAUSE_W-1:0]  evt;
   logic [15:0]                  int_en_reg;
   logic                         test_reg;
   logic                         sclk_q_reg;
   logic [3:0]                   bitcnt_reg;
   logic [15:0]                  sin_reg;
   logic [15:0]                  sout_reg;
   logic [13:0]                  ser_addr_reg;
   logic                         p_take;
   logic                         p_wr;
   logic [13:0]                  p_off;
   logic                         s_rise;
   logic                         s_fall;
   logic                         s_last;
   logic                         s_wr;
   logic [15:0]                  s_word;
   logic                         dma_cap;
   logic                         wr_en;
   logic [13:0]                  wr_off;
   logic [15:0]                  wr_data;
   logic [13:0]                  rd_off;
   logic [15:0]                  rd_word;
   logic                         rd_cause;

   hrp_mem_if mem_bus ();

   hrp_regmem u_mem (
      .clk_sys (clk_sys),
      .rst     (rst),
      .port    (mem_bus.mem)
   );

   // ==========================================================
   // Address decode
   // ==========================================================
   function automatic logic is_mapped(input logic [13:0] off);
      case (off)
         hrp_pkg::OFF_INT_ENABLE, hrp_pkg::OFF_INT_CAUSE, hrp_pkg::OFF_PEND_CH_SEL,
         hrp_pkg::OFF_ACT_CH_SEL, hrp_pkg::OFF_PEND_CH_FILT, hrp_pkg::OFF_ACT_FILT_A,
         hrp_pkg::OFF_ACT_FILT_B, hrp_pkg::OFF_TRACK_SEL, hrp_pkg::OFF_BUF_HANDLING,
         hrp_pkg::OFF_CHIP_CTL, hrp_pkg::OFF_ADPCM_MIRROR, hrp_pkg::OFF_AUDIO_LEFT,
         hrp_pkg::OFF_AUDIO_RIGHT, hrp_pkg::OFF_AUDIO_LOUD, hrp_pkg::OFF_AUDIO_CTL,
         hrp_pkg::OFF_AUDIO_SETUP, hrp_pkg::OFF_AUDIO_STATE, hrp_pkg::OFF_INT_STEER,
         hrp_pkg::OFF_XFER_CTL, hrp_pkg::OFF_MICROCODE: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // Read-only words live outside the memory, so writes to them are dropped
   function automatic logic is_writable(input logic [13:0] off);
      is_writable = is_mapped(off) && off != hrp_pkg::OFF_INT_CAUSE && off != hrp_pkg::OFF_AUDIO_STATE;
   endfunction

   // Global reset pin is sampled like any other input
   assign rst = sys_rst || !global_reset_n;

   // ==========================================================
   // Clock output
   // ==========================================================
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         osc_q_reg <= 1'b0;
         div_reg   <= 1'b0;
      end else begin
         osc_q_reg <= oscillator_double_in;
         // Toggling on every oscillator rise divides by OSC_DIVIDE, which is two
         if (oscillator_double_in && !osc_q_reg) begin
            div_reg <= !div_reg;
         end
      end
   end

   assign divided_clock_output = div_reg;

   // ==========================================================
   // Parallel access
   // ==========================================================
   assign p_off  = {word_addr, 1'b0};
   assign p_take = host_port_select && !dev_select_n && pstate_reg == hrp_pkg::P_IDLE
                   && dstate_reg == hrp_pkg::D_IDLE;
   assign p_wr   = p_take && !read_not_write;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pstate_reg   <= hrp_pkg::P_IDLE;
         data_out_reg <= hrp_pkg::REG_RESET;
         data_oe_reg  <= 1'b0;
      end else begin
         case (pstate_reg)
            hrp_pkg::P_IDLE: begin
               if (p_take) begin
                  pstate_reg <= read_not_write ? hrp_pkg::P_RD : hrp_pkg::P_ACK;
               end
            end
            hrp_pkg::P_RD: begin
               // Data goes on the bus in the same cycle acknowledge falls
               data_out_reg <= rd_word;
               data_oe_reg  <= 1'b1;
               pstate_reg   <= hrp_pkg::P_ACK;
            end
            hrp_pkg::P_ACK: begin
               if (dev_select_n) begin
                  data_oe_reg <= 1'b0;
                  pstate_reg  <= hrp_pkg::P_PULL;
               end
            end
            hrp_pkg::P_PULL: begin
               pstate_reg <= hrp_pkg::P_IDLE;
            end
            default: begin
               pstate_reg <= hrp_pkg::P_IDLE;
            end
         endcase
      end
   end

   assign data_out = data_out_reg;
   assign data_oe  = data_oe_reg;
   // Acknowledge is released with one driven-high cycle; no new access drives it while DMA is busy
   assign transfer_acknowledge_n_out = pstate_reg != hrp_pkg::P_ACK;
   assign transfer_acknowledge_n_oe  = pstate_reg == hrp_pkg::P_ACK || pstate_reg == hrp_pkg::P_PULL;

   // ==========================================================
   // DMA engine
   // ==========================================================
   assign dma_cap = dstate_reg == hrp_pkg::D_XFER && !transfer_acknowledge_n_in;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dstate_reg <= hrp_pkg::D_IDLE;
         last_reg   <= 1'b0;
      end else begin
         case (dstate_reg)
            hrp_pkg::D_IDLE: begin
               if (p_wr && p_off == hrp_pkg::OFF_XFER_CTL && data_in[hrp_pkg::XFER_START_BIT]) begin
                  dstate_reg <= hrp_pkg::D_REQ;
               end
            end
            hrp_pkg::D_REQ: begin
               if (!dma_grant_n) begin
                  dstate_reg <= hrp_pkg::D_XFER;
               end
            end
            hrp_pkg::D_XFER: begin
               if (dma_cap) begin
                  last_reg   <= !dma_done_n;
                  dstate_reg <= hrp_pkg::D_RDY;
               end
            end
            hrp_pkg::D_RDY: begin
               if (transfer_acknowledge_n_in) begin
                  dstate_reg <= hrp_pkg::D_REL;
               end
            end
            hrp_pkg::D_REL: begin
               dstate_reg <= last_reg ? hrp_pkg::D_IDLE : hrp_pkg::D_XFER;
            end
            default: begin
               dstate_reg <= hrp_pkg::D_IDLE;
            end
         endcase
      end
   end

   assign dma_request_n   = dstate_reg == hrp_pkg::D_IDLE;
   assign dma_ready_n_out = dstate_reg != hrp_pkg::D_RDY;
   assign dma_ready_n_oe  = dstate_reg == hrp_pkg::D_RDY || dstate_reg == hrp_pkg::D_REL;

   // ==========================================================
   // Serial link
   // ==========================================================
   assign s_rise = !host_port_select && serial_clock && !sclk_q_reg;
   assign s_fall = !host_port_select && !serial_clock && sclk_q_reg;
   assign s_last = s_rise && bitcnt_reg == hrp_pkg::SER_LAST_BIT;
   assign s_word = {sin_reg[14:0], serial_data_in};
   assign s_wr   = s_last && serial_op == hrp_pkg::OP_WRITE;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclk_q_reg <= 1'b0;
         bitcnt_reg <= 4'h0;
         sin_reg    <= hrp_pkg::REG_RESET;
      end else begin
         sclk_q_reg <= serial_clock;
         if (s_rise) begin
            bitcnt_reg <= bitcnt_reg + 4'h1;
            sin_reg    <= s_word;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ser_addr_reg <= 14'h0000;
      end else if (s_last && serial_op == hrp_pkg::OP_ADDR) begin
         ser_addr_reg <= s_word[13:0];
      end
   end

   // Between frames the shifter keeps reloading, so it always holds the addressed word
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sout_reg <= hrp_pkg::REG_RESET;
      end else if (bitcnt_reg == 4'h0) begin
         sout_reg <= rd_word;
      end else if (s_fall) begin
         sout_reg <= {sout_reg[14:0], 1'b0};
      end
   end

   assign serial_data_out = sout_reg[15];

   // ==========================================================
   // Shared register access
   // ==========================================================
   always_comb begin
      wr_en   = 1'b0;
      wr_off  = p_off;
      wr_data = data_in;
      if (dma_cap) begin
         wr_en  = 1'b1;
         wr_off = hrp_pkg::OFF_ADPCM_MIRROR;
      end else if (p_wr) begin
         wr_en = 1'b1;
      end else if (s_wr) begin
         wr_en   = 1'b1;
         wr_off  = ser_addr_reg;
         wr_data = s_word;
      end
   end

   assign mem_bus.we    = wr_en && is_writable(wr_off);
   assign mem_bus.waddr = wr_off[6:1];
   assign mem_bus.wdata = wr_data;
   assign rd_off        = host_port_select ? p_off : ser_addr_reg;
   assign mem_bus.raddr = rd_off[6:1];

   always_comb begin
      case (rd_off)
         hrp_pkg::OFF_INT_CAUSE:   rd_word = {{(16 - hrp_pkg::CAUSE_W){1'b0}}, cause_reg};
         hrp_pkg::OFF_AUDIO_STATE: rd_word = {12'h000, dstate_reg != hrp_pkg::D_IDLE, test_reg,
                                              host_port_select, last_reg};
         hrp_pkg::OFF_MICROCODE:   rd_word = hrp_pkg::REG_RESET;
         default:                  rd_word = is_mapped(rd_off) ? mem_bus.rdata : hrp_pkg::REG_RESET;
      endcase
   end

   // ==========================================================
   // Control shadows and interrupt
   // ==========================================================
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         int_en_reg <= hrp_pkg::REG_RESET;
         test_reg   <= 1'b0;
      end else if (wr_en) begin
         if (wr_off == hrp_pkg::OFF_INT_ENABLE) begin
            int_en_reg <= wr_data;
         end
         if (wr_off == hrp_pkg::OFF_CHIP_CTL) begin
            test_reg <= wr_data[hrp_pkg::CTL_TEST_BIT];
         end
      end
   end

   assign test_indicator = test_reg;

   assign evt[hrp_pkg::CAUSE_DMA_END]  = dstate_reg == hrp_pkg::D_REL && last_reg;
   assign evt[hrp_pkg::CAUSE_DMA_WORD] = dma_cap;
   assign rd_cause = (pstate_reg == hrp_pkg::P_RD && p_off == hrp_pkg::OFF_INT_CAUSE)
                     || (s_last && serial_op == hrp_pkg::OP_READ && ser_addr_reg == hrp_pkg::OFF_INT_CAUSE)
                     || !alert_acknowledge_n;
   // A new event in the clearing cycle survives the clear
   assign cause_next = (rd_cause ? '0 : cause_reg) | evt;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cause_reg <= '0;
      end else begin
         cause_reg <= cause_next;
      end
   end

   assign alert_n = !(|(cause_reg & int_en_reg[hrp_pkg::CAUSE_W-1:0]));

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_deselect_ignored: assert property (pstate_reg == hrp_pkg::P_IDLE && dev_select_n
      |=> pstate_reg == hrp_pkg::P_IDLE && !transfer_acknowledge_n_oe) else $error("select ignored");
   a_strap_blocks_bus: assert property (!host_port_select && !dev_select_n
      && pstate_reg == hrp_pkg::P_IDLE |=> !transfer_acknowledge_n_oe && !data_oe)
      else $error("parallel access in serial mode");
   a_read_data_first: assert property (p_take && read_not_write
      |=> transfer_acknowledge_n_out ##1 data_oe && !transfer_acknowledge_n_out && transfer_acknowledge_n_oe)
      else $error("read acknowledge before data");
   a_write_ack_next: assert property (p_take && !read_not_write
      |-> mem_bus.we == is_writable(p_off) ##1 !transfer_acknowledge_n_out && !data_oe)
      else $error("write not taken");
   a_ack_pull_high: assert property (pstate_reg == hrp_pkg::P_ACK && dev_select_n
      |=> transfer_acknowledge_n_oe && transfer_acknowledge_n_out ##1 !transfer_acknowledge_n_oe)
      else $error("acknowledge not pulled high");
   a_alert_release: assert property (!alert_n && pstate_reg == hrp_pkg::P_RD && p_off == hrp_pkg::OFF_INT_CAUSE
      && evt == '0 |=> alert_n) else $error("alert not released");
   a_grant_first: assert property (dstate_reg == hrp_pkg::D_REQ && dma_grant_n
      |=> !dma_request_n && !dma_ready_n_oe) else $error("transfer before grant");
   a_ready_release: assert property (dstate_reg == hrp_pkg::D_RDY && transfer_acknowledge_n_in
      |=> dma_ready_n_oe && dma_ready_n_out ##1 !dma_ready_n_oe) else $error("ready release wrong");
   a_done_ends_burst: assert property (dma_cap && !dma_done_n
      ##1 transfer_acknowledge_n_in |=> ##1 dma_request_n && cause_reg[hrp_pkg::CAUSE_DMA_END])
      else $error("burst not ended");
   a_serial_noop: assert property (s_last && serial_op == hrp_pkg::OP_NONE
      |-> !mem_bus.we ##1 $stable(ser_addr_reg)) else $error("serial no-op acted");
   a_clock_halved: assert property (oscillator_double_in && !osc_q_reg
      |=> divided_clock_output != $past(divided_clock_output)) else $error("clock not divided");
   a_test_flag: assert property (p_wr && p_off == hrp_pkg::OFF_CHIP_CTL
      |=> test_indicator == $past(data_in[hrp_pkg::CTL_TEST_BIT])) else $error("test flag wrong");

   c_parallel_read: cover property (p_take && read_not_write ##2 !transfer_acknowledge_n_out);
   c_dma_burst: cover property (dma_cap && dma_done_n ##[1:20] dma_cap && !dma_done_n);
   c_serial_write: cover property (s_wr && mem_bus.we);
   c_alert_cycle: cover property ($fell(alert_n) ##[1:50] $rose(alert_n));

endmodule

// ### sim/hrp_dma_partner.sv
`timescale 1ns/10ps
// ==========================
// Memory side of a DMA burst
// ==========================
module hrp_dma_partner (
   // Clock
   input  wire logic        clk_sys,
   // Device handshake
   input  wire logic        dma_request_n,
   input  wire logic        dma_ready_n_out,
   input  wire logic        dma_ready_n_oe,
   input  wire logic [15:0] first_word,
   // Far side drives
   output logic             dma_grant_n,
   output logic             mem_ack_n,
   output logic             dma_done_n,
   output logic [15:0]      mem_data
);
   int n;
   initial begin
      dma_grant_n = 1'b1;
      mem_ack_n = 1'b1;
      dma_done_n = 1'b1;
      mem_data = 16'h0000;
      forever begin
         @(negedge clk_sys);
         if (dma_request_n === 1'b0) begin
            // Grant lands before the first word is offered
            repeat (2) @(posedge clk_sys);
            dma_grant_n <= 1'b0;
            for (int k = 0; k < 3; k++) begin
               @(posedge clk_sys);
               mem_data <= first_word + 16'(k);
               mem_ack_n <= 1'b0;
               dma_done_n <= (k == 2) ? 1'b0 : 1'b1;
               n = 0;
               do @(negedge clk_sys); while (!(dma_ready_n_oe === 1'b1 && dma_ready_n_out === 1'b0) && ++n < 20);
               @(posedge clk_sys);
               mem_ack_n <= 1'b1;
               dma_done_n <= 1'b1;
               // A released bus must not keep showing the last word
               mem_data <= ~(first_word + 16'(k));
               n = 0;
               do @(negedge clk_sys); while (dma_ready_n_oe !== 1'b0 && ++n < 20);
            end
            n = 0;
            do @(negedge clk_sys); while (dma_request_n !== 1'b1 && ++n < 20);
            dma_grant_n <= 1'b1;
         end
      end
   end
endmodule

// ### sim/host_register_port_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, s); end end
module host_register_port_bench;
   logic clk_sys, sys_rst, grst_n, osc, strap, sel_n, rw;
   logic [13:1] addr;
   logic [15:0] hd, dout, din, mdata, q, w, first;
   logic oe, ack_o, ack_oe, alert_n, req_n, gnt_n, rdy_o, rdy_oe, done_n, mack_n, tst, dclk, ok, p;
   logic sclk, mosi, miso;
   logic [1:0] sop;
   logic [15:0] r;
   logic [13:0] tbl [7] = '{14'h2588, 14'h258A, 14'h25A0, 14'h25A2, 14'h25A4, 14'h2584, 14'h2592};
   int seed = 46039;
   int failures = 0;
   int comparisons = 0;
   int c;
   assign din = (gnt_n === 1'b0) ? mdata : hd;
   hrp_host_port hrp_host_port_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .global_reset_n(grst_n),
      .oscillator_double_in(osc), .divided_clock_output(dclk), .host_port_select(strap), .test_indicator(tst),
      .word_addr(addr), .dev_select_n(sel_n), .read_not_write(rw), .data_in(din), .data_out(dout),
      .data_oe(oe), .transfer_acknowledge_n_in(ack_oe ? ack_o : mack_n), .transfer_acknowledge_n_out(ack_o),
      .transfer_acknowledge_n_oe(ack_oe), .alert_n(alert_n), .alert_acknowledge_n(1'b1),
      .dma_request_n(req_n), .dma_grant_n(gnt_n), .dma_ready_n_out(rdy_o), .dma_ready_n_oe(rdy_oe),
      .dma_done_n(done_n), .serial_clock(sclk), .serial_data_in(mosi), .serial_data_out(miso), .serial_op(sop));
   hrp_dma_partner hrp_dma_partner_i (.clk_sys(clk_sys), .dma_request_n(req_n), .dma_ready_n_out(rdy_o),
      .dma_ready_n_oe(rdy_oe), .first_word(first), .dma_grant_n(gnt_n), .mem_ack_n(mack_n),
      .dma_done_n(done_n), .mem_data(mdata));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task test_done;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========================
   // One host access, bounded
   // ==========================
   task bus(input logic r, input logic [13:0] a, input logic [15:0] d, output logic [15:0] v, output logic k);
      int n;
      @(posedge clk_sys);
      addr <= a[13:1];
      rw <= r;
      hd <= d;
      // Address settles a cycle before select
      @(posedge clk_sys);
      sel_n <= 1'b0;
      n = 0;
      do @(negedge clk_sys); while (!(ack_oe === 1'b1 && ack_o === 1'b0) && ++n < 12);
      k = (n < 12);
      v = dout;
      if (k && r) `CHK("data_oe", 1'b1, oe)
      @(posedge clk_sys);
      sel_n <= 1'b1;
      hd <= ~d;
      n = 0;
      do @(negedge clk_sys); while (ack_oe !== 1'b0 && ++n < 12);
      if (k) `CHK("ack_pull", 1'b1, ack_o)
   endtask
   // One serial frame: 16 rises, reply sampled once per bit after the rise
   task ser(input logic [1:0] o, input logic [15:0] d);
      for (int b = 0; b < 17; b++) begin
         @(posedge clk_sys);
         sclk <= 1'b0;
         mosi <= d[15];
         sop <= o;
         d = {d[14:0], 1'b0};
         if (b < 16) begin
            @(posedge clk_sys);
            sclk <= 1'b1;
            @(negedge clk_sys);
            r = {r[14:0], miso};
         end
      end
   endtask
   task wr(input logic [13:0] a, input logic [15:0] d);
      bus(1'b0, a, d, q, ok);
      `CHK("wr_ack", 1'b1, ok)
   endtask
   task rd(input logic [13:0] a, input logic [15:0] e);
      bus(1'b1, a, 16'h0000, q, ok);
      `CHK("rd_ack", 1'b1, ok)
      `CHK("rd_data", e, q)
   endtask
   initial begin
      {sys_rst, grst_n, strap, sel_n, rw, osc, addr, hd, first} = {5'b11111, 1'b0, 13'h0000, 32'h0000_0000};
      {sclk, mosi, sop} = 4'h3;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      `CHK("alert_rst", 1'b1, alert_n)
      `CHK("req_rst", 1'b1, req_n)
      `CHK("test_rst", 1'b0, tst)
      for (int i = 0; i < 21; i++) begin
         w = 16'($random(seed));
         wr(tbl[i % 7], w);
         rd(tbl[i % 7], w);
      end
      wr(14'h2586, 16'hFFFF);
      rd(14'h2586, 16'h0000);
      rd(14'h2400, 16'h0000);
      wr(14'h2596, 16'h0001);
      `CHK("test_on", 1'b1, tst)
      wr(14'h2596, 16'h0000);
      `CHK("test_off", 1'b0, tst)
      first = 16'($random(seed));
      wr(14'h2584, 16'h0003);
      wr(14'h25C2, 16'h0001);
      c = 0;
      do @(negedge clk_sys); while (req_n !== 1'b1 && ++c < 200);
      `CHK("dma_end", 1'b1, req_n)
      `CHK("alert_on", 1'b0, alert_n)
      rd(14'h259A, first + 16'h0002);
      rd(14'h2586, 16'h0003);
      `CHK("alert_off", 1'b1, alert_n)
      strap <= 1'b0;
      bus(1'b0, 14'h2588, 16'h1234, q, ok);
      `CHK("strap_block", 1'b0, ok)
      strap <= 1'b1;
      wr(14'h2588, 16'hA5A5);
      @(posedge clk_sys);
      grst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      grst_n <= 1'b1;
      rd(14'h2588, 16'h0000);
      c = 0;
      for (int i = 0; i < 8; i++) begin
         p = dclk;
         @(posedge clk_sys);
         osc <= ~osc;
         @(negedge clk_sys);
         c += (dclk !== p);
      end
      `CHK("clk_div", 4, c)
      w = 16'($random(seed));
      strap <= 1'b0;
      ser(2'h2, 16'h2588);
      ser(2'h0, w);
      ser(2'h1, 16'h0000);
      `CHK("miso", w, r)
      ser(2'h3, 16'h0000);
      strap <= 1'b1;
      rd(14'h2588, w);
      test_done;
   end
endmodule
